// ---- hdl/efs_pkg.sv ----
package efs_pkg;
    // register map
    localparam logic [6:0]  HALT_PARAMS_ADDR = 7'h4E;
    localparam int          HALT_DECEL_LSB   = 0;
    localparam int          HALT_DECEL_W     = 24;
    localparam int          HALT_SCALE_LSB   = 24;
    localparam int          HALT_SCALE_W     = 8;
    localparam logic [31:0] HALT_PARAMS_RST  = 32'h0000_0000;
    // event flag word
    localparam int          HALT_EVENT_BIT   = 10;
    localparam int          EVENT_W          = 32;
    // input filter length in samples
    localparam int          FILT_SAMPLES     = 3;
    // velocity width
    localparam int          VEL_W            = 32;
    localparam int          SCALE_W          = 8;
    // ramp states
    typedef enum logic [1:0] {
        EFS_RUN,
        EFS_DECEL,
        EFS_STOPPED
    } efs_state_t;
endpackage : efs_pkg

// ---- hdl/efs_filter.sv ----
`timescale 1ns/1ns
// ------------------------------------------------------------
// input synchroniser and glitch filter
// ------------------------------------------------------------
module efs_filter
    import efs_pkg::*;
#(
    parameter int SAMPLES = FILT_SAMPLES
) (
    input  wire logic clk,       // system clock
    input  wire logic rst,       // async reset, high
    input  wire logic pin_n,     // raw pin, low active
    output logic      level_n    // filtered level
);
    logic               meta_q;
    logic               sync_q;
    logic [SAMPLES-1:0] hist_q;

    // two-stage synchroniser, idles high
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
        end else begin
            meta_q <= pin_n;
            sync_q <= meta_q;
        end
    end

    // shift history of synchronised samples
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hist_q <= '1;
        end else begin
            hist_q <= {hist_q[SAMPLES-2:0], sync_q};
        end
    end

    // equal samples required
    // level only moves once all samples agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            level_n <= 1'b1;
        end else if (hist_q == '0) begin
            level_n <= 1'b0;
        end else if (hist_q == '1) begin
            level_n <= 1'b1;
        end
    end
endmodule : efs_filter

// ---- hdl/efs_top.sv ----
`timescale 1ns/1ns
// Functional notes
// - falling halt input stops ramp at once
// - halt sets sticky event bit 10
// - input needs three equal samples
// - input polarity fixed active low
// - halt register holds decel and scale
// - halt register written once before ramp
// - halt register always readable
// - zero decel hard stop, else linear
// - decel is raw per-cycle velocity step
// - nonzero scale applies, zero keeps last
// - halt scale applied like normal scale
module efs_top
    import efs_pkg::*;
(
    input  wire logic               clk,           // system clock 25 MHz
    input  wire logic               rst,           // async reset, high
    input  wire logic               halt_input_n,  // safety pin, low active
    input  wire logic               wr_en,         // host register write strobe
    input  wire logic [6:0]         wr_addr,       // host write address
    input  wire logic [31:0]        wr_data,       // host write data
    input  wire logic [6:0]         rd_addr,       // host read address
    output logic      [31:0]        rd_data,       // read data
    input  wire logic               ramp_start,    // ramp generator start pulse
    input  wire logic signed [VEL_W-1:0] ramp_vel, // velocity from ramp generator
    input  wire logic [SCALE_W-1:0] norm_scale,    // normal scaling value
    output logic signed [VEL_W-1:0] vel_out,       // velocity actually applied
    output logic [SCALE_W-1:0]      scale_out,     // active current scale
    output logic                    ramp_block,    // ramp generator must hold
    output logic [EVENT_W-1:0]      event_flag_word // sticky event_flag_word
);
    logic                    halt_lvl_n;
    logic                    halt_lvl_d1_q;
    logic                    halt_fall;
    logic [31:0]             halt_params_q;
    logic                    halt_locked_q;
    logic                    ramp_seen_q;
    logic                    halted_event_q;
    efs_state_t              state_q;
    logic signed [VEL_W-1:0] vel_q;
    logic [SCALE_W-1:0]      scale_q;
    logic [HALT_DECEL_W-1:0] halt_decel;
    logic [HALT_SCALE_W-1:0] halt_scale;
    logic signed [VEL_W-1:0] step;

    assign halt_decel = halt_params_q[HALT_DECEL_LSB +: HALT_DECEL_W];
    assign halt_scale = halt_params_q[HALT_SCALE_LSB +: HALT_SCALE_W];
    assign step       = VEL_W'(signed'({1'b0, halt_decel}));

    // ------------------------------------------------------------
    // input filtering
    // ------------------------------------------------------------
    // no inversion option
    efs_filter #(.SAMPLES(FILT_SAMPLES)) u_filt (
        .clk     (clk),
        .rst     (rst),
        .pin_n   (halt_input_n),
        .level_n (halt_lvl_n)
    );

    // edge detect on the filtered level only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            halt_lvl_d1_q <= 1'b1;
        end else begin
            halt_lvl_d1_q <= halt_lvl_n;
        end
    end
    assign halt_fall = halt_lvl_d1_q & ~halt_lvl_n;

    // ------------------------------------------------------------
    // halt parameter register
    // ------------------------------------------------------------
    // track whether any ramp started since reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ramp_seen_q <= 1'b0;
        end else if (ramp_start) begin
            ramp_seen_q <= 1'b1;
        end
    end

    // single write before ramp start
    // locking protects against corrupted host traffic after setup
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            halt_params_q <= HALT_PARAMS_RST;
            halt_locked_q <= 1'b0;
        end else if (wr_en && wr_addr == HALT_PARAMS_ADDR) begin
            halt_locked_q <= 1'b1;
            if (!halt_locked_q && !ramp_seen_q && !ramp_start) begin
                halt_params_q <= wr_data;
            end
        end
    end

    always_comb begin
        rd_data = 32'h0000_0000;
        if (rd_addr == HALT_PARAMS_ADDR) begin
            rd_data = halt_params_q;
        end
    end

    // ------------------------------------------------------------
    // event and stop state
    // ------------------------------------------------------------
    // sticky until reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            halted_event_q <= 1'b0;
        end else if (halt_fall) begin
            halted_event_q <= 1'b1;
        end
    end

    always_comb begin
        event_flag_word                 = '0;
        event_flag_word[HALT_EVENT_BIT] = halted_event_q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= EFS_RUN;
        end else begin
            case (state_q)
                EFS_RUN: begin
                    if (halt_fall) begin
                        state_q <= (halt_decel == '0) ? EFS_STOPPED : EFS_DECEL;
                    end
                end
                EFS_DECEL: begin
                    if (vel_q == '0) begin
                        state_q <= EFS_STOPPED;
                    end
                end
                EFS_STOPPED: state_q <= EFS_STOPPED;
                default:     state_q <= EFS_STOPPED;
            endcase
        end
    end

    // raw step per clock, no unit scaling
    // magnitude clamps at zero so direction never reverses
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vel_q <= '0;
        end else begin
            case (state_q)
                EFS_RUN: begin
                    if (halt_fall && halt_decel == '0) begin
                        vel_q <= '0;
                    end else begin
                        vel_q <= ramp_vel;
                    end
                end
                EFS_DECEL: begin
                    if (vel_q > step) begin
                        vel_q <= vel_q - step;
                    end else if (vel_q < -step) begin
                        vel_q <= vel_q + step;
                    end else begin
                        vel_q <= '0;
                    end
                end
                default: vel_q <= '0;
            endcase
        end
    end
    assign vel_out = vel_q;

    assign ramp_block = halted_event_q;

    // ------------------------------------------------------------
    // current scale selection
    // ------------------------------------------------------------
    // zero keeps the last pre-halt value
    // output feeds the same scaling path
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scale_q <= '0;
        end else if (!halted_event_q && !halt_fall) begin
            scale_q <= norm_scale;
        end else if (halt_scale != '0) begin
            scale_q <= halt_scale;
        end
    end
    assign scale_out = scale_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_fall_zero;
        halt_fall && halt_decel == '0;
    endsequence

    a_event_sticky: assert property (@(posedge clk) disable iff (rst)
        halted_event_q |=> halted_event_q)
        else $error("halt event cleared");
    a_event_sets: assert property (@(posedge clk) disable iff (rst)
        halt_fall |=> halted_event_q && state_q != EFS_RUN)
        else $error("halt edge not taken");
    a_hard_stop: assert property (@(posedge clk) disable iff (rst)
        s_fall_zero |=> vel_q == '0 ##1 vel_q == '0)
        else $error("hard stop failed");
    a_decel_step: assert property (@(posedge clk) disable iff (rst)
        state_q == EFS_DECEL && vel_q > step |=> vel_q == $past(vel_q) - step)
        else $error("decel step wrong");
    a_params_lock: assert property (@(posedge clk) disable iff (rst)
        halt_locked_q |=> halt_params_q == $past(halt_params_q))
        else $error("halt params changed after lock");
    a_params_read: assert property (@(posedge clk) disable iff (rst)
        rd_addr == HALT_PARAMS_ADDR |-> rd_data == halt_params_q)
        else $error("halt params read wrong");
    a_scale_halt: assert property (@(posedge clk) disable iff (rst)
        halted_event_q && halt_scale != '0 |=> scale_q == halt_scale)
        else $error("halt scale not applied");
    a_scale_keep: assert property (@(posedge clk) disable iff (rst)
        halted_event_q && halt_scale == '0 |=> $stable(scale_q))
        else $error("scale moved after halt");
    a_stays_still: assert property (@(posedge clk) disable iff (rst)
        state_q == EFS_STOPPED |-> vel_q == '0 && ramp_block)
        else $error("motion after stop");
endmodule : efs_top

// ---- dv/efs_safety_model.sv ----
`timescale 1ns/1ns
// ------------------------------------------------------------
// board safety logic: pulls the halt pin low on request
// ------------------------------------------------------------
module efs_safety_model (
    input  wire logic       clk,     // system clock
    input  wire logic       req,     // start a low pulse
    input  wire logic [3:0] len,     // pulse length in cycles
    output logic            halt_n   // drives the halt pin
);
    logic [3:0] cnt_q = 4'h0;

    // hold low for len cycles
    // plain always: the start value above must not clash with a single-writer process
    always @(posedge clk) begin
        if (req)
            cnt_q <= len;
        else if (cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
    end

    // pin idles high, low is the active level
    assign halt_n = (cnt_q == 4'h0);
endmodule : efs_safety_model

// ---- dv/emergency_freeze_stop_test.sv ----
`timescale 1ns/1ns
module emergency_freeze_stop_test;
    import efs_pkg::*;
    logic                    clk = 0, rst = 1, wr_en = 0, ramp_start = 0, req = 0;
    logic [6:0]              wr_addr = 0, rd_addr = 0;
    logic [31:0]             wr_data = 0, rd_data, event_flag_word, model_reg;
    logic signed [VEL_W-1:0] ramp_vel = 0, vel_out;
    logic [SCALE_W-1:0]      norm_scale = 0, scale_out, sc, last_sc;
    logic                    halt_input_n, ramp_block;
    logic [3:0]              low_len = 0;
    int                      errors = 0, total_checks = 0, cycles = 0, v, dec, exp_v;

    always #20 clk = ~clk;

    efs_safety_model safety_u (.clk(clk), .req(req), .len(low_len), .halt_n(halt_input_n));

    efs_top dut_u (.clk(clk), .rst(rst), .halt_input_n(halt_input_n), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data),
        .ramp_start(ramp_start), .ramp_vel(ramp_vel), .norm_scale(norm_scale),
        .vel_out(vel_out), .scale_out(scale_out), .ramp_block(ramp_block),
        .event_flag_word(event_flag_word));

    task automatic chk(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1) begin
            errors++;
            $display("unexpected %0t %s", $time, m);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    // hang guard, runs need a few hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            tally_and_finish();
        end
    end

    task automatic wr(input logic [31:0] dat);
        @(posedge clk);
        wr_en <= 1;
        wr_addr <= HALT_PARAMS_ADDR;
        wr_data <= dat;
        @(posedge clk);
        wr_en <= 0;
    endtask : wr

    task automatic rd(input logic [6:0] a, input logic [31:0] e);
        @(posedge clk);
        rd_addr <= a;
        @(posedge clk);
        #1;
        chk(rd_data === e, "read data");
    endtask : rd

    task automatic pulse(input logic [3:0] n);
        @(posedge clk);
        req <= 1;
        low_len <= n;
        @(posedge clk);
        req <= 0;
    endtask : pulse

    // one life of the device; late puts the write after the ramp start
    task automatic run(input logic late);
        @(posedge clk);
        rst <= 1;
        ramp_vel <= '0; // motor must read still right after reset
        repeat (20) @(posedge clk);
        rst <= 0;
        dec = late ? 0 : $urandom_range(60, 20);
        sc = late ? 8'h00 : 8'($urandom_range(255, 1));
        model_reg = late ? 32'h0 : {sc, 24'(dec)};
        rd(HALT_PARAMS_ADDR, 32'h0);
        rd(7'h11, 32'h0);
        chk(event_flag_word === 32'h0 && vel_out === 0, "reset outputs");
        pulse(4'h2);
        repeat (12) @(posedge clk);
        chk(event_flag_word === 32'h0 && ramp_block === 1'b0, "short pulse taken");
        if (!late) begin
            wr(model_reg);
            rd(HALT_PARAMS_ADDR, model_reg);
            wr(~model_reg);
        end
        v = $urandom_range(900, 300);
        @(posedge clk);
        norm_scale <= 8'($urandom_range(255, 1));
        ramp_vel <= VEL_W'(v);
        ramp_start <= 1;
        @(posedge clk);
        ramp_start <= 0;
        if (late)
            wr($urandom);
        rd(HALT_PARAMS_ADDR, model_reg);
        chk(vel_out === VEL_W'(v) && scale_out === norm_scale, "running values");
        pulse(4'h3);
        exp_v = v;
        // velocity model: each change must be one decel step toward zero
        for (int i = 0; i < 60; i++) begin
            @(posedge clk);
            #1;
            if (vel_out !== VEL_W'(exp_v)) begin
                exp_v = (dec == 0 || exp_v <= dec) ? 0 : exp_v - dec;
                chk(vel_out === VEL_W'(exp_v), "decel step");
            end
        end
        chk(vel_out === 0 && event_flag_word === 32'h400, "halt event");
        last_sc = (sc != 0) ? sc : norm_scale;
        chk(scale_out === last_sc, "halt scale");
        rd(HALT_PARAMS_ADDR, model_reg);
        @(posedge clk);
        ramp_vel <= VEL_W'(v + 5);
        norm_scale <= ~norm_scale; // a zero halt scale must not follow this
        ramp_start <= 1;
        @(posedge clk);
        ramp_start <= 0;
        repeat (4) @(posedge clk);
        #1;
        chk(vel_out === 0 && ramp_block === 1'b1, "restart taken");
        chk(scale_out === last_sc, "scale left halt value");
        chk(event_flag_word[HALT_EVENT_BIT] === 1'b1, "event lost");
    endtask : run

    initial begin
        void'($urandom(52));
        run(1'b0);
        run(1'b1);
        tally_and_finish();
    end
endmodule : emergency_freeze_stop_test
